// ### rtl/psr_pkg.sv
package psr_pkg;
    localparam logic [7:0] OFF_SEC_CFG = 8'h05;
    localparam logic [7:0] OFF_OSC_CTRL = 8'h06;
    localparam logic [7:0] OFF_OSC_CNT0 = 8'h07;
    localparam logic [7:0] OFF_OSC_CNT3 = 8'h0A;
    localparam logic [7:0] OFF_MEM_SIZE = 8'h0C;
    localparam logic [7:0] OFF_DEBUG_SAVED_STATUS = 8'h10;
    localparam logic [7:0] OFF_DEBUG_SAVED_PC = 8'h11;
    localparam logic [7:0] OFF_DEBUG_SAVED_STACK_PTR = 8'h12;
    localparam logic [7:0] OFF_DBG_TSEL = 8'h13;
    localparam logic [7:0] OFF_DBG_RSEL = 8'h14;
    localparam int BIT_WRITE_LOCK = 31;
    localparam int BIT_GLOBAL_DBG_OFF = 14;
    localparam int BIT_OTP_RD_LOCK = 9;
    localparam int BIT_OTP_PROG_OFF = 8;
    localparam int BIT_OTP_COMBINE = 7;
    localparam int BIT_FORCE_OTP_BOOT = 5;
    localparam int BIT_PLL_BOOT_JTAG_OFF = 4;
    localparam int BIT_DEBUG_TAP_OFF = 0;
    localparam int BIT_CORE_OSC_EN = 1;
    localparam int BIT_PERIPH_OSC_EN = 0;
    localparam logic [31:0] SEC_CFG_MASK = 32'h800043B1;
    localparam logic [31:0] SSR_MASK = 32'h000007DF;
    localparam logic [31:0] SSR_WR_MASK = 32'h000006DF;
    localparam logic [31:0] OSC_CTRL_MASK = 32'h00000003;
    localparam logic [31:0] TSEL_MASK = 32'h000000FF;
    localparam logic [31:0] RSEL_MASK = 32'h0000001F;
    localparam logic [31:0] MEM_SIZE_MASK = 32'hFFFFFFFC;
    localparam logic [1:0] OSC_CTRL_RESET = 2'h0;
    localparam int OSC_COUNT_W = 16;
    localparam int NUM_OSC = 4;
    typedef struct packed {
        logic [31:0] saved_status_word;
        logic [31:0] saved_prog_counter;
        logic [31:0] saved_stack_pointer;
    } dbg_capture_s;
    typedef struct packed {
        logic global_dbg_off;
        logic otp_rd_lock;
        logic otp_program_port_off;
        logic otp_combined_space;
        logic force_otp_boot;
        logic pll_boot_jtag_off;
        logic debug_tap_off;
    } sec_ctrl_s;
endpackage

// ### rtl/proc_status_regs.sv
// Summary of operation
// R01 - Bit 31 of security config, once set, blocks all later state-access writes to it until reset clears it; an OTP security word load still reloads it.
// R02 - Security config loads from the OTP security word.
// R03 - Security bit 14 denies global debug access.
// R04 - Security bit 9 refuses OTP reads.
// R05 - Security bit 8 blocks the OTP programming port.
// R06 - Security bit 7 presents OTP as one combined read space.
// R07 - Security bit 5 forces boot from OTP, ignoring boot mode.
// R08 - Security bit 4 refuses JTAG access to PLL/boot registers.
// R09 - Security bit 0 denies the debug TAP.
// R10 - Four free-running oscillators each clock their own counter, started by control.
// R11 - Control bit 1 core enable, bit 0 peripheral enable, reset zero.
// R12 - Software reads counters only after stop of 10 core cycles.
// R13 - Counter values in bits 15:0, read-only, kept across reset.
// R14 - Oscillators asynchronous; counts brought safely into core clock domain.
// R15 - RAM size read-only in bits 31:2, bits 1:0 zero.
// R16 - Debug entry captures status word into saved status register.
// R17 - Debug entry captures 32-bit program counter; writable in debug.
// R18 - Debug entry captures 32-bit stack pointer.
// R19 - Thread select operand holds logical core id in bits 7:0.
// R20 - Register select operand holds register number in bits 4:0.
// R21 - Reserved bits read zero, writes to them ignored.
// R22 - Debug registers writable only in debug mode.
`timescale 1ns/100ps
`default_nettype none
module proc_status_regs
    import psr_pkg::*;
#(
    parameter logic [31:0] MEM_SIZE = 32'h00080000
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Ring oscillator clocks
    input wire logic [NUM_OSC-1:0] osc_clk,
    // OTP security word load
    input wire logic sec_load,
    input wire logic [31:0] sec_otp_word,
    // Processor state access
    input wire logic ps_wr,
    input wire logic ps_rd,
    input wire logic [7:0] ps_addr,
    input wire logic [31:0] ps_wdata,
    output logic [31:0] ps_rdata,
    // Debug state
    input wire logic dbg_mode,
    input wire logic dbg_entry,
    input wire dbg_capture_s dbg_cap,
    // Security controls
    output sec_ctrl_s sec_ctrl,
    // Oscillator enables
    output logic core_osc_en,
    output logic periph_osc_en
);
    logic [31:0] sec_q;
    logic [1:0] osc_ctrl_q;
    logic [31:0] ssr_q, spc_q, ssp_q, tsel_q, rsel_q;
    logic [31:0] rdata_q;
    logic [OSC_COUNT_W-1:0] cnt_sync [NUM_OSC];

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction

    wire logic wr_sec = ps_wr && hit(ps_addr, OFF_SEC_CFG)
        && !sec_q[BIT_WRITE_LOCK]; // see R01
    wire logic wr_osc = ps_wr && hit(ps_addr, OFF_OSC_CTRL);
    wire logic dwr = ps_wr && dbg_mode; // see R22
    wire logic [31:0] ssr_wval = (ps_wdata & SSR_WR_MASK)
        | (ssr_q & ~SSR_WR_MASK); // see R21

    // Security register
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sec_q <= 32'h00000000;
        end else if (sec_load) begin
            sec_q <= sec_otp_word & SEC_CFG_MASK; // see R02
        end else if (wr_sec) begin
            sec_q <= ps_wdata & SEC_CFG_MASK; // see R21
        end
    end

    assign sec_ctrl.global_dbg_off = sec_q[BIT_GLOBAL_DBG_OFF]; // see R03
    assign sec_ctrl.otp_rd_lock = sec_q[BIT_OTP_RD_LOCK]; // see R04
    assign sec_ctrl.otp_program_port_off = sec_q[BIT_OTP_PROG_OFF]; // see R05
    assign sec_ctrl.otp_combined_space = sec_q[BIT_OTP_COMBINE]; // see R06
    assign sec_ctrl.force_otp_boot = sec_q[BIT_FORCE_OTP_BOOT]; // see R07
    assign sec_ctrl.pll_boot_jtag_off = sec_q[BIT_PLL_BOOT_JTAG_OFF]; // see R08
    assign sec_ctrl.debug_tap_off = sec_q[BIT_DEBUG_TAP_OFF]; // see R09

    // Oscillator control
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            osc_ctrl_q <= OSC_CTRL_RESET; // see R11
        end else if (wr_osc) begin
            osc_ctrl_q <= ps_wdata[1:0];
        end
    end
    assign core_osc_en = osc_ctrl_q[BIT_CORE_OSC_EN]; // see R11
    assign periph_osc_en = osc_ctrl_q[BIT_PERIPH_OSC_EN]; // see R11

    // Per-oscillator counter and crossing
    genvar g;
    generate
        for (g = 0; g < NUM_OSC; g++) begin : g_osc
            logic en_m, en_s;
            logic [OSC_COUNT_W-1:0] cnt = '0;
            logic [OSC_COUNT_W-1:0] gray, gm, gs;
            logic run;
            // Oscillators 0,1 are tile ones, 2,3 peripheral
            assign run = (g < 2) ? osc_ctrl_q[BIT_CORE_OSC_EN]
                : osc_ctrl_q[BIT_PERIPH_OSC_EN];
            // Enable into oscillator domain, no reset so count survives
            always_ff @(posedge osc_clk[g]) begin
                en_m <= run;
                en_s <= en_m;
            end
            always_ff @(posedge osc_clk[g]) begin
                if (en_s) begin
                    cnt <= cnt + 1'b1; // see R10
                end
                gray <= (cnt >> 1) ^ cnt;
            end
            // Gray count into core domain
            always_ff @(posedge core_clk) begin
                gm <= gray; // see R14
                gs <= gm;
            end
            always_comb begin
                cnt_sync[g][OSC_COUNT_W-1] = gs[OSC_COUNT_W-1];
                for (int i = OSC_COUNT_W-2; i >= 0; i--) begin
                    cnt_sync[g][i] = cnt_sync[g][i+1] ^ gs[i];
                end
            end
        end
    endgenerate

    // Debug save registers
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ssr_q <= 32'h00000000;
            spc_q <= 32'h00000000;
            ssp_q <= 32'h00000000;
            tsel_q <= 32'h00000000;
            rsel_q <= 32'h00000000;
        end else if (dbg_entry) begin
            ssr_q <= dbg_cap.saved_status_word & SSR_MASK; // see R16
            spc_q <= dbg_cap.saved_prog_counter; // see R17
            ssp_q <= dbg_cap.saved_stack_pointer; // see R18
        end else if (dwr) begin
            if (hit(ps_addr, OFF_DEBUG_SAVED_STATUS)) begin
                ssr_q <= ssr_wval; // see R22
            end
            if (hit(ps_addr, OFF_DEBUG_SAVED_PC)) begin
                spc_q <= ps_wdata; // see R17
            end
            if (hit(ps_addr, OFF_DEBUG_SAVED_STACK_PTR)) begin
                ssp_q <= ps_wdata; // see R18
            end
            if (hit(ps_addr, OFF_DBG_TSEL)) begin
                tsel_q <= ps_wdata & TSEL_MASK; // see R19
            end
            if (hit(ps_addr, OFF_DBG_RSEL)) begin
                rsel_q <= ps_wdata & RSEL_MASK; // see R20
            end
        end
    end

    // Read mux
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h00000000;
        unique case (ps_addr)
            OFF_SEC_CFG: rd_mux = sec_q;
            OFF_OSC_CTRL: rd_mux = {30'h0, osc_ctrl_q};
            8'h07: rd_mux = {16'h0, cnt_sync[0]}; // see R13
            8'h08: rd_mux = {16'h0, cnt_sync[1]}; // see R13
            8'h09: rd_mux = {16'h0, cnt_sync[2]}; // see R13
            OFF_OSC_CNT3: rd_mux = {16'h0, cnt_sync[3]}; // see R13
            OFF_MEM_SIZE: rd_mux = MEM_SIZE & MEM_SIZE_MASK; // see R15
            OFF_DEBUG_SAVED_STATUS: rd_mux = ssr_q;
            OFF_DEBUG_SAVED_PC: rd_mux = spc_q;
            OFF_DEBUG_SAVED_STACK_PTR: rd_mux = ssp_q;
            OFF_DBG_TSEL: rd_mux = tsel_q;
            OFF_DBG_RSEL: rd_mux = rsel_q;
            default: rd_mux = 32'h00000000; // see R21
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rdata_q <= 32'h00000000;
        end else if (ps_rd) begin
            rdata_q <= rd_mux;
        end
    end
    assign ps_rdata = rdata_q;

    // Assertions
    property p_lock;
        @(posedge core_clk) disable iff (!rst_n)
        (sec_q[BIT_WRITE_LOCK] && !sec_load) |=> $stable(sec_q);
    endproperty
    a_lock: assert property (p_lock) // see R01
        else $error("locked security register changed");

    property p_load;
        @(posedge core_clk) disable iff (!rst_n)
        sec_load |=> sec_q == ($past(sec_otp_word) & SEC_CFG_MASK);
    endproperty
    a_load: assert property (p_load) // see R02
        else $error("security word not loaded");

    property p_tap;
        @(posedge core_clk) disable iff (!rst_n)
        sec_ctrl.debug_tap_off == sec_q[0] && sec_ctrl.global_dbg_off == sec_q[14];
    endproperty
    a_tap: assert property (p_tap) // see R09
        else $error("debug disables wrong");

    property p_oscrst;
        @(posedge core_clk) !rst_n |=> osc_ctrl_q == 2'h0;
    endproperty
    a_oscrst: assert property (p_oscrst) // see R11
        else $error("oscillator control not reset");

    property p_capture;
        @(posedge core_clk) disable iff (!rst_n)
        dbg_entry |=> spc_q == $past(dbg_cap.saved_prog_counter) && ssp_q == $past(dbg_cap.saved_stack_pointer);
    endproperty
    a_capture: assert property (p_capture) // see R17
        else $error("debug capture missed");

    property p_nodbgwr;
        @(posedge core_clk) disable iff (!rst_n)
        (!dbg_mode && !dbg_entry) |=> $stable(spc_q) && $stable(tsel_q);
    endproperty
    a_nodbgwr: assert property (p_nodbgwr) // see R22
        else $error("debug register written outside debug");

    property p_resv;
        @(posedge core_clk) disable iff (!rst_n)
        ps_rd ##1 1'b1 |-> (tsel_q[31:8] == 24'h0 && rsel_q[31:5] == 27'h0);
    endproperty
    a_resv: assert property (p_resv) // see R21
        else $error("reserved bits set");

    property p_memsz;
        @(posedge core_clk) disable iff (!rst_n)
        (ps_rd && ps_addr == OFF_MEM_SIZE) |=> ps_rdata[1:0] == 2'h0;
    endproperty
    a_memsz: assert property (p_memsz) // see R15
        else $error("memory size low bits set");

    property p_cnt;
        @(posedge core_clk) disable iff (!rst_n)
        (ps_rd && ps_addr == OFF_OSC_CNT0) |=> ps_rdata[31:16] == 16'h0;
    endproperty
    a_cnt: assert property (p_cnt) // see R13
        else $error("counter upper bits set");

    property p_lockwr;
        @(posedge core_clk) disable iff (!rst_n)
        (ps_wr && ps_addr == OFF_SEC_CFG && sec_q[BIT_WRITE_LOCK]
            && !sec_load) |=> $stable(sec_q);
    endproperty
    a_lockwr: assert property (p_lockwr) // see R01
        else $error("write reached locked security register");

    property p_secwr;
        @(posedge core_clk) disable iff (!rst_n)
        (ps_wr && ps_addr == OFF_SEC_CFG && !sec_q[BIT_WRITE_LOCK]
            && !sec_load) |=> sec_q == ($past(ps_wdata) & SEC_CFG_MASK);
    endproperty
    a_secwr: assert property (p_secwr) // see R21
        else $error("security write not masked");

    property p_secresv;
        @(posedge core_clk) disable iff (!rst_n)
        (sec_q & ~SEC_CFG_MASK) == 32'h00000000;
    endproperty
    a_secresv: assert property (p_secresv) // see R21
        else $error("security reserved bits set");

    property p_dbgoff;
        @(posedge core_clk) disable iff (!rst_n)
        sec_ctrl.global_dbg_off == sec_q[BIT_GLOBAL_DBG_OFF];
    endproperty
    a_dbgoff: assert property (p_dbgoff) // see R03
        else $error("global debug disable wrong");

    property p_otprd;
        @(posedge core_clk) disable iff (!rst_n)
        sec_ctrl.otp_rd_lock == sec_q[BIT_OTP_RD_LOCK];
    endproperty
    a_otprd: assert property (p_otprd) // see R04
        else $error("otp read lock wrong");

    property p_otpprog;
        @(posedge core_clk) disable iff (!rst_n)
        sec_ctrl.otp_program_port_off == sec_q[BIT_OTP_PROG_OFF];
    endproperty
    a_otpprog: assert property (p_otpprog) // see R05
        else $error("otp program port block wrong");

    property p_otpcomb;
        @(posedge core_clk) disable iff (!rst_n)
        sec_ctrl.otp_combined_space == sec_q[BIT_OTP_COMBINE];
    endproperty
    a_otpcomb: assert property (p_otpcomb) // see R06
        else $error("otp combined space wrong");

    property p_boot;
        @(posedge core_clk) disable iff (!rst_n)
        sec_ctrl.force_otp_boot == sec_q[BIT_FORCE_OTP_BOOT];
    endproperty
    a_boot: assert property (p_boot) // see R07
        else $error("forced otp boot wrong");

    property p_pll;
        @(posedge core_clk) disable iff (!rst_n)
        sec_ctrl.pll_boot_jtag_off == sec_q[BIT_PLL_BOOT_JTAG_OFF];
    endproperty
    a_pll: assert property (p_pll) // see R08
        else $error("pll boot jtag block wrong");

    property p_oscwr;
        @(posedge core_clk) disable iff (!rst_n)
        (ps_wr && ps_addr == OFF_OSC_CTRL)
            |=> {30'h0, osc_ctrl_q} == ($past(ps_wdata) & OSC_CTRL_MASK);
    endproperty
    a_oscwr: assert property (p_oscwr) // see R11
        else $error("oscillator control write lost");

    property p_oscen;
        @(posedge core_clk) disable iff (!rst_n)
        core_osc_en == osc_ctrl_q[BIT_CORE_OSC_EN]
            && periph_osc_en == osc_ctrl_q[BIT_PERIPH_OSC_EN];
    endproperty
    a_oscen: assert property (p_oscen) // see R11
        else $error("oscillator enable outputs wrong");

    property p_ssrcap;
        @(posedge core_clk) disable iff (!rst_n)
        dbg_entry |=> ssr_q == ($past(dbg_cap.saved_status_word) & SSR_MASK);
    endproperty
    a_ssrcap: assert property (p_ssrcap) // see R16
        else $error("status word not captured");

    property p_sspwr;
        @(posedge core_clk) disable iff (!rst_n)
        (dwr && !dbg_entry && ps_addr == OFF_DEBUG_SAVED_STACK_PTR)
            |=> ssp_q == $past(ps_wdata);
    endproperty
    a_sspwr: assert property (p_sspwr) // see R18
        else $error("stack pointer write lost");

    property p_tselwr;
        @(posedge core_clk) disable iff (!rst_n)
        (dwr && !dbg_entry && ps_addr == OFF_DBG_TSEL)
            |=> tsel_q == ($past(ps_wdata) & TSEL_MASK);
    endproperty
    a_tselwr: assert property (p_tselwr) // see R19
        else $error("thread select write wrong");

    property p_rselwr;
        @(posedge core_clk) disable iff (!rst_n)
        (dwr && !dbg_entry && ps_addr == OFF_DBG_RSEL)
            |=> rsel_q == ($past(ps_wdata) & RSEL_MASK);
    endproperty
    a_rselwr: assert property (p_rselwr) // see R20
        else $error("register select write wrong");

    property p_ssrro;
        @(posedge core_clk) disable iff (!rst_n)
        (dwr && !dbg_entry && ps_addr == OFF_DEBUG_SAVED_STATUS)
            |=> $stable(ssr_q[8]);
    endproperty
    a_ssrro: assert property (p_ssrro) // see R21
        else $error("read-only status bit written");

    property p_rdhold;
        @(posedge core_clk) disable iff (!rst_n)
        !ps_rd |=> $stable(ps_rdata);
    endproperty
    a_rdhold: assert property (p_rdhold) // see R13
        else $error("read data changed without read");
endmodule
`default_nettype wire

// ### verification/core_model.sv
`timescale 1ns/100ps
`default_nettype none
module core_model
    import psr_pkg::*;
(
    // Clock
    input wire logic core_clk,
    // State access requests
    output logic ps_wr,
    output logic ps_rd,
    output logic [7:0] ps_addr,
    output logic [31:0] ps_wdata,
    // Read answer
    input wire logic [31:0] ps_rdata
);
    initial begin
        ps_wr = 1'b0;
        ps_rd = 1'b0;
        ps_addr = 8'h00;
        ps_wdata = 32'h00000000;
    end

    // Set state: one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge core_clk);
        ps_addr = a;
        ps_wdata = d;
        ps_wr = 1'b1;
        @(negedge core_clk);
        ps_wr = 1'b0;
    endtask

    // Get state: data taken a cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(negedge core_clk);
        ps_addr = a;
        ps_rd = 1'b1;
        @(negedge core_clk);
        ps_rd = 1'b0;
        @(negedge core_clk);
        d = ps_rdata;
    endtask

    // Idle after stopping oscillators before reading counts
    task automatic osc_settle();
        repeat (10) @(negedge core_clk);
    endtask
endmodule
`default_nettype wire

// ### verification/tb_processor_status_security_debug_regs.sv
`timescale 1ns/100ps
`default_nettype none
module tb_processor_status_security_debug_regs;
    import psr_pkg::*;
    localparam logic [31:0] MEM_SZ = 32'h00080003;
    logic core_clk, rst_n, sec_load, ps_wr, ps_rd, dbg_mode, dbg_entry;
    logic core_osc_en, periph_osc_en;
    logic [3:0] osc_clk;
    logic [7:0] ps_addr;
    logic [31:0] sec_otp_word, ps_wdata, ps_rdata, v;
    logic [31:0] cnt [4];
    dbg_capture_s dbg_cap;
    sec_ctrl_s sec_ctrl;
    int err_total = 0;
    int checked = 0;

    proc_status_regs #(.MEM_SIZE(MEM_SZ)) u_dut (.core_clk(core_clk),
        .rst_n(rst_n), .osc_clk(osc_clk), .sec_load(sec_load),
        .sec_otp_word(sec_otp_word), .ps_wr(ps_wr), .ps_rd(ps_rd),
        .ps_addr(ps_addr), .ps_wdata(ps_wdata), .ps_rdata(ps_rdata),
        .dbg_mode(dbg_mode), .dbg_entry(dbg_entry), .dbg_cap(dbg_cap),
        .sec_ctrl(sec_ctrl), .core_osc_en(core_osc_en),
        .periph_osc_en(periph_osc_en));
    core_model u_core (.core_clk(core_clk), .ps_wr(ps_wr), .ps_rd(ps_rd),
        .ps_addr(ps_addr), .ps_wdata(ps_wdata), .ps_rdata(ps_rdata));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always #3.3 osc_clk[0] = ~osc_clk[0];
    always #4.1 osc_clk[1] = ~osc_clk[1];
    always #2.7 osc_clk[2] = ~osc_clk[2];
    always #3.9 osc_clk[3] = ~osc_clk[3];

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic do_reset();
        @(negedge core_clk);
        rst_n = 1'b0;
        repeat (3) @(negedge core_clk);
        rst_n = 1'b1;
    endtask

    task automatic t_reset_values();
        u_core.rd(OFF_OSC_CTRL, v);
        chk(v, 32'h00000000);
        chk({30'h0, core_osc_en, periph_osc_en}, 32'h00000000);
        u_core.rd(OFF_MEM_SIZE, v);
        chk(v, 32'h00080000);
        u_core.rd(8'h0B, v);
        chk(v, 32'h00000000);
    endtask

    task automatic t_sec_bits();
        int pos [7];
        pos = '{BIT_GLOBAL_DBG_OFF, BIT_OTP_RD_LOCK, BIT_OTP_PROG_OFF,
            BIT_OTP_COMBINE, BIT_FORCE_OTP_BOOT, BIT_PLL_BOOT_JTAG_OFF,
            BIT_DEBUG_TAP_OFF};
        for (int i = 0; i < 7; i++) begin
            @(negedge core_clk);
            sec_otp_word = 32'h00000001 << pos[i];
            sec_load = 1'b1;
            @(negedge core_clk);
            sec_load = 1'b0;
            @(negedge core_clk);
            chk({25'h0, sec_ctrl}, 32'h00000040 >> i);
            u_core.rd(OFF_SEC_CFG, v);
            chk(v, sec_otp_word);
        end
    endtask

    task automatic t_sec_lock();
        u_core.wr(OFF_SEC_CFG, 32'h7FFFFFFF);
        u_core.rd(OFF_SEC_CFG, v);
        chk(v, 32'h000043B1);
        chk({25'h0, sec_ctrl}, 32'h0000007F);
        u_core.wr(OFF_SEC_CFG, 32'h80000000);
        u_core.wr(OFF_SEC_CFG, 32'hFFFFFFFF);
        u_core.rd(OFF_SEC_CFG, v);
        chk(v, 32'h80000000);
    endtask

    task automatic t_osc();
        u_core.wr(OFF_OSC_CTRL, 32'hFFFFFFFE);
        chk({30'h0, core_osc_en, periph_osc_en}, 32'h00000002);
        u_core.wr(OFF_OSC_CTRL, 32'h00000001);
        chk({30'h0, core_osc_en, periph_osc_en}, 32'h00000001);
        u_core.wr(OFF_OSC_CTRL, 32'h00000003);
        u_core.rd(OFF_OSC_CTRL, v);
        chk(v, 32'h00000003);
        repeat (60) @(negedge core_clk);
        u_core.wr(OFF_OSC_CTRL, 32'h00000000);
        u_core.osc_settle();
        for (int i = 0; i < 4; i++) begin
            u_core.rd(OFF_OSC_CNT0 + 8'(i), cnt[i]);
            chk(cnt[i] & 32'hFFFF0000, 32'h00000000);
            checked++;
            if (cnt[i][15:0] == 16'h0000) begin
                err_total++;
                $display("BAD t=%0t got=%h exp=%h", $time, cnt[i],
                    32'h00000001);
            end
        end
        do_reset();
        for (int i = 0; i < 4; i++) begin
            u_core.rd(OFF_OSC_CNT0 + 8'(i), v);
            chk(v, cnt[i]);
        end
    endtask

    task automatic t_debug();
        @(negedge core_clk);
        dbg_cap = '{saved_status_word: 32'hFFFFFFFF, saved_prog_counter: 32'h12345678, saved_stack_pointer: 32'h9ABCDEF0};
        dbg_entry = 1'b1;
        @(negedge core_clk);
        dbg_entry = 1'b0;
        u_core.rd(OFF_DEBUG_SAVED_STATUS, v);
        chk(v, SSR_MASK);
        u_core.rd(OFF_DEBUG_SAVED_PC, v);
        chk(v, 32'h12345678);
        u_core.rd(OFF_DEBUG_SAVED_STACK_PTR, v);
        chk(v, 32'h9ABCDEF0);
        u_core.wr(OFF_DEBUG_SAVED_PC, 32'h00000000);
        u_core.rd(OFF_DEBUG_SAVED_PC, v);
        chk(v, 32'h12345678);
        dbg_mode = 1'b1;
        u_core.wr(OFF_DEBUG_SAVED_STATUS, 32'h00000000);
        u_core.rd(OFF_DEBUG_SAVED_STATUS, v);
        chk(v, 32'h00000100);
        u_core.wr(OFF_DEBUG_SAVED_PC, 32'hCAFE0001);
        u_core.rd(OFF_DEBUG_SAVED_PC, v);
        chk(v, 32'hCAFE0001);
        u_core.wr(OFF_DBG_TSEL, 32'hFFFFFFFF);
        u_core.rd(OFF_DBG_TSEL, v);
        chk(v, 32'h000000FF);
        u_core.wr(OFF_DBG_RSEL, 32'hFFFFFFFF);
        u_core.rd(OFF_DBG_RSEL, v);
        chk(v, 32'h0000001F);
    endtask

    task automatic report_and_stop();
        $display("checked=%0d err_total=%0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        #200000;
        err_total++;
        report_and_stop();
    end

    initial begin
        rst_n = 1'b0;
        osc_clk = 4'h0;
        sec_load = 1'b0;
        sec_otp_word = 32'h00000000;
        dbg_mode = 1'b0;
        dbg_entry = 1'b0;
        dbg_cap = '0;
        do_reset();
        t_reset_values();
        t_sec_bits();
        t_sec_lock();
        t_osc();
        t_debug();
        report_and_stop();
    end
endmodule
`default_nettype wire
